// *** common/emu_profile_pkg.sv ***
// Shared constants, types and decode functions for the emulation profile status registers.
package emu_profile_pkg;

  // Register offsets on the management serial bus.
  localparam logic [7:0] ADDR_PROFILE_IND = 8'h30;
  localparam logic [7:0] ADDR_FIRST_STIMULUS_SOURCE_TIMING = 8'h31;
  localparam logic [7:0] ADDR_FIRST_STIMULUS_SOURCE_RESP = 8'h32;

  // Power-on values, and the value read from unmapped addresses.
  localparam logic [7:0] RST_PROFILE_IND = 8'h00;
  localparam logic [7:0] RST_FIRST_STIMULUS_SOURCE_TIMING = 8'h00;
  localparam logic [7:0] RST_FIRST_STIMULUS_SOURCE_RESP = 8'h26;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Field positions.
  localparam int PROFILE_CODE_LSB = 0;
  localparam int TIMER_MODE_BIT = 6;
  localparam int DELAY_LSB = 3;
  localparam int SOURCE_LSB = 0;
  localparam int MAG_LSB = 4;
  localparam int TYPE_LSB = 0;

  // Profile codes.
  localparam logic [3:0] PROFILE_PASS_SDP = 4'h0;
  localparam logic [3:0] PROFILE_CDP = 4'h1;
  localparam logic [3:0] PROFILE_DCP = 4'h2;
  localparam logic [3:0] PROFILE_LEGACY_FIRST = 4'h3;
  localparam logic [3:0] PROFILE_LEGACY_LAST = 4'h9;
  localparam logic [3:0] PROFILE_CUSTOM = 4'hA;

  // Timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [6:0] DELAY_MS_TABLE [8] = '{7'h00, 7'h01, 7'h05, 7'h0A,
                                               7'h14, 7'h28, 7'h50, 7'h64};

  localparam logic [3:0] MAG_RESERVED = 4'hF;

  typedef enum logic [2:0] {
    SRC_VBUS_READY = 3'b000,
    SRC_DP_HIGH = 3'b001,
    SRC_DP_WINDOW = 3'b010,
    SRC_DM_HIGH = 3'b011,
    SRC_RSVD_A = 3'b100,
    SRC_RSVD_B = 3'b101,
    SRC_DP_HIGH_ALT = 3'b110,
    SRC_VBUS_PRESENT = 3'b111
  } stim_src_t;

  typedef enum logic [1:0] {
    CLASS_NONE = 2'b00,
    CLASS_VOLTAGE = 2'b01,
    CLASS_RESISTOR = 2'b10,
    CLASS_DIVIDER = 2'b11
  } resp_class_t;

  function automatic resp_class_t resp_class(input logic [3:0] rtype);
    case (rtype)
      4'h0, 4'h1, 4'h2, 4'h3: resp_class = CLASS_VOLTAGE;
      4'h4, 4'h7, 4'hD, 4'hE, 4'hF: resp_class = CLASS_RESISTOR;
      4'h6, 4'h9, 4'hC: resp_class = CLASS_DIVIDER;
      default: resp_class = CLASS_NONE;
    endcase
  endfunction : resp_class

  function automatic logic src_usable(input logic [2:0] src);
    src_usable = (src != SRC_RSVD_A) && (src != SRC_RSVD_B);
  endfunction : src_usable

  function automatic logic type_usable(input logic [3:0] rtype);
    type_usable = (rtype != 4'h5) && (rtype != 4'h8) && (rtype != 4'hB);
  endfunction : type_usable

endpackage : emu_profile_pkg

// *** rtl/stim_engine.sv ***
// First-stimulus detector and timer that drives the response on the data output pins.
`timescale 1ns/1ns
module stim_engine #(
  parameter int MS_CYC = emu_profile_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic halt,
  input wire logic timer_mode,
  input wire logic [2:0] delay_code,
  input wire emu_profile_pkg::stim_src_t source,
  input wire logic [3:0] type_in,
  input wire logic [3:0] mag_in,
  input wire logic vbus_ready,
  input wire logic vbus_present,
  input wire logic dp_above_th,
  input wire logic dm_above_th,
  input wire logic dp_above_floor,
  output logic resp_on,
  output emu_profile_pkg::resp_class_t resp_kind,
  output logic [3:0] resp_type,
  output logic [3:0] resp_mag,
  output logic stage_done
);
  import emu_profile_pkg::*;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000,
    ENG_ARMED = 3'b001,
    ENG_DELAY = 3'b010,
    ENG_HOLD = 3'b011,
    ENG_APPLIED = 3'b100
  } eng_state_t;

  typedef struct packed {
    eng_state_t st;
    logic [31:0] cnt;
    logic on;
    logic done;
    logic [3:0] rtype;
    logic [3:0] mag;
  } eng_t;

  eng_t q_r;
  eng_t q_nxt;
  logic detect;
  logic vbus_src;
  logic [31:0] delay_cyc;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (source)
      SRC_VBUS_READY: detect = vbus_ready;
      SRC_VBUS_PRESENT: detect = vbus_present;
      SRC_DP_HIGH, SRC_DP_HIGH_ALT: detect = dp_above_th;
      SRC_DM_HIGH: detect = dm_above_th;
      // The floor comparator only exists on the positive pin.
      SRC_DP_WINDOW: detect = !dp_above_th && dp_above_floor;
      default: detect = 1'b0;
    endcase
  end

  // Vbus stimuli let the next stage go on without waiting for removal.
  assign vbus_src = (source == SRC_VBUS_READY) || (source == SRC_VBUS_PRESENT);
  assign delay_cyc = 32'(DELAY_MS_TABLE[delay_code]) * 32'(MS_CYC);

  always_comb begin
    q_nxt = q_r;
    case (q_r.st)
      ENG_IDLE: begin
        q_nxt.st = ENG_IDLE;
      end
      ENG_ARMED: begin
        if (detect) begin
          q_nxt.cnt = delay_cyc;
          if (timer_mode) begin
            q_nxt.on = 1'b1;
            q_nxt.st = (delay_cyc == 32'h0) ? ENG_APPLIED : ENG_HOLD;
          end else if (delay_cyc == 32'h0) begin
            q_nxt.on = 1'b1;
            q_nxt.st = ENG_APPLIED;
          end else begin
            q_nxt.st = ENG_DELAY;
          end
        end
      end
      ENG_DELAY: begin
        q_nxt.cnt = q_r.cnt - 32'h1;
        if (q_r.cnt == 32'h1) begin
          q_nxt.on = 1'b1;
          q_nxt.st = ENG_APPLIED;
        end
      end
      ENG_HOLD: begin
        q_nxt.cnt = q_r.cnt - 32'h1;
        if (q_r.cnt == 32'h1) begin
          q_nxt.st = ENG_APPLIED;
        end
      end
      ENG_APPLIED: begin
        if (vbus_src || !detect) begin
          q_nxt.done = 1'b1;
          q_nxt.st = ENG_IDLE;
          if (timer_mode && !detect) begin
            q_nxt.on = 1'b0;
          end
        end
      end
      default: q_nxt.st = ENG_IDLE;
    endcase
    if (start) begin
      q_nxt.st = ENG_ARMED;
      q_nxt.cnt = 32'h0;
      q_nxt.on = 1'b0;
      q_nxt.done = 1'b0;
      q_nxt.rtype = type_in;
      q_nxt.mag = mag_in;
    end
    if (halt) begin
      q_nxt.st = ENG_IDLE;
      q_nxt.on = 1'b0;
      q_nxt.done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '{st: ENG_IDLE, cnt: 32'h0, on: 1'b0, done: 1'b0,
               rtype: RST_FIRST_STIMULUS_SOURCE_RESP[TYPE_LSB +: 4], mag: RST_FIRST_STIMULUS_SOURCE_RESP[MAG_LSB +: 4]};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign resp_on = q_r.on;
  assign resp_type = q_r.rtype;
  assign resp_mag = q_r.mag;
  assign resp_kind = resp_class(q_r.rtype);
  assign stage_done = q_r.done;

endmodule : stim_engine

// *** rtl/emulation_profile_status_regs.sv ***
// Active profile indicator and first-stimulus configuration registers with their engine.
`timescale 1ns/1ns

// How it works
// - Profile indicator register clears on sleep entry.
// - Indicator refreshes when applied profile changes.
// - Four-bit profile code, upper bits read zero.
// - Timer mode 1: respond now, hold, remove; a vbus stimulus still present keeps it on.
// - Timer mode 0: respond when delay expires.
// - Delay codes map to 0-100 ms.
// - Source codes 100 and 101 are refused.
// - Source 000 is vbus ready, no wait.
// - Source 111 is vbus present, no wait.
// - Sources 001/110 positive, 011 negative above threshold.
// - Source 010 is positive-pin window comparator.
// - Reserved codes refused; field keeps old value.
// - Magnitude meaning follows the response type.
// - Types 0000-0011 take magnitude as voltage.
// - Types 0100/0111/1101-1111 take magnitude as resistor.
// - Types 0110/1001/1100 take magnitude as divider.
// - Configuration registers read-only, filled from memory.
// - Timing register clears in sleep; response register keeps.
module emulation_profile_status_regs
  import emu_profile_pkg::*;
#(
  parameter int MS_CYC = emu_profile_pkg::MS_CYCLES,
  parameter int PROFILES = 11,
  parameter logic [16*11-1:0] PROFILE_INIT = {11{16'h0026}}
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0] profile_sel,
  input wire logic profile_load,
  input wire logic sleep,
  input wire logic vbus_ready,
  input wire logic vbus_present,
  input wire logic dp_above_th,
  input wire logic dm_above_th,
  input wire logic dp_above_floor,
  output logic [3:0] active_profile_code,
  output logic resp_on,
  output emu_profile_pkg::resp_class_t resp_kind,
  output logic [3:0] first_response_type,
  output logic [3:0] first_response_magnitude,
  output logic stage_done
);
  import emu_profile_pkg::*;

  localparam int NSYNC = 5;

  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [3:0] profile;
    logic [7:0] timing;
    logic [7:0] resp;
    logic loaded;
    logic start;
    logic [7:0] rdata;
    logic rvalid;
  } regs_t;

  regs_t q_r;
  regs_t q_nxt;

  // Preloaded profile settings: upper byte is the timing/source word, lower the response.
  logic [15:0] profile_mem [PROFILES];
  logic [15:0] word;
  logic load_go;
  logic [2:0] new_src;
  logic [3:0] new_type;
  logic [3:0] new_mag;

  ////////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < PROFILES; gi++) begin : g_mem
      assign profile_mem[gi] = PROFILE_INIT[gi*16 +: 16];
    end
  endgenerate

  // Codes above the custom profile are not used and never select a word.
  assign word = (profile_sel <= PROFILE_CUSTOM) ? profile_mem[profile_sel] : 16'h0000;
  assign new_src = word[8 + SOURCE_LSB +: 3];
  assign new_type = word[TYPE_LSB +: 4];
  assign new_mag = word[MAG_LSB +: 4];

  // Reload only on a different profile, or the first load after reset or sleep wiped the indicator.
  assign load_go = profile_load && !sleep && (profile_sel <= PROFILE_CUSTOM)
                   && (!q_r.loaded || (profile_sel != q_r.profile));

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    q_nxt = q_r;
    q_nxt.sync1 = {dp_above_floor, dm_above_th, dp_above_th, vbus_present, vbus_ready};
    q_nxt.sync2 = q_r.sync1;
    q_nxt.start = 1'b0;
    if (load_go) begin
      q_nxt.profile = profile_sel;
      q_nxt.loaded = 1'b1;
      // The custom profile keeps its settings elsewhere; these registers stay untouched.
      if (profile_sel != PROFILE_CUSTOM) begin
        q_nxt.start = 1'b1;
        q_nxt.timing[TIMER_MODE_BIT] = word[8 + TIMER_MODE_BIT];
        q_nxt.timing[DELAY_LSB +: 3] = word[8 + DELAY_LSB +: 3];
        if (src_usable(new_src)) begin
          q_nxt.timing[SOURCE_LSB +: 3] = new_src;
        end
        if (type_usable(new_type)) begin
          q_nxt.resp[TYPE_LSB +: 4] = new_type;
        end
        if (new_mag != MAG_RESERVED) begin
          q_nxt.resp[MAG_LSB +: 4] = new_mag;
        end
      end
    end
    if (sleep) begin
      q_nxt.profile = RST_PROFILE_IND[PROFILE_CODE_LSB +: 4];
      q_nxt.timing = RST_FIRST_STIMULUS_SOURCE_TIMING;
      q_nxt.loaded = 1'b0;
    end
    // Software only reads; there is no write path into these registers.
    q_nxt.rvalid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_PROFILE_IND: q_nxt.rdata = {4'h0, q_r.profile};
        ADDR_FIRST_STIMULUS_SOURCE_TIMING: q_nxt.rdata = {1'b0, q_r.timing[6:0]};
        ADDR_FIRST_STIMULUS_SOURCE_RESP: q_nxt.rdata = q_r.resp;
        default: q_nxt.rdata = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '{sync1: '0, sync2: '0, profile: RST_PROFILE_IND[PROFILE_CODE_LSB +: 4],
               timing: RST_FIRST_STIMULUS_SOURCE_TIMING, resp: RST_FIRST_STIMULUS_SOURCE_RESP, loaded: 1'b0,
               start: 1'b0, rdata: 8'h00, rvalid: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The engine latches the response word on start, one cycle after the registers load.
  stim_engine #(
    .MS_CYC(MS_CYC)
  ) i_stim_engine (
    .clk(clk),
    .rstn(rstn),
    .start(q_r.start),
    .halt(sleep),
    .timer_mode(q_r.timing[TIMER_MODE_BIT]),
    .delay_code(q_r.timing[DELAY_LSB +: 3]),
    .source(stim_src_t'(q_r.timing[SOURCE_LSB +: 3])),
    .type_in(q_r.resp[TYPE_LSB +: 4]),
    .mag_in(q_r.resp[MAG_LSB +: 4]),
    .vbus_ready(q_r.sync2[0]),
    .vbus_present(q_r.sync2[1]),
    .dp_above_th(q_r.sync2[2]),
    .dm_above_th(q_r.sync2[3]),
    .dp_above_floor(q_r.sync2[4]),
    .resp_on(resp_on),
    .resp_kind(resp_kind),
    .resp_type(first_response_type),
    .resp_mag(first_response_magnitude),
    .stage_done(stage_done)
  );

  assign reg_rdata = q_r.rdata;
  assign reg_rvalid = q_r.rvalid;
  assign active_profile_code = q_r.profile;

endmodule : emulation_profile_status_regs

// *** bench/emu_profile_assertions.sv ***
// Checker for the emulation profile status registers, bound to the top module.
`timescale 1ns/1ns
module emu_profile_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [3:0] profile_sel,
  input wire logic profile_load,
  input wire logic sleep,
  input wire logic [3:0] active_profile_code,
  input wire emu_profile_pkg::resp_class_t resp_kind,
  input wire logic [3:0] first_response_type
);
  import emu_profile_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_no_spurious;
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without read");
  property p_ind_read;
    reg_rd && reg_addr == ADDR_PROFILE_IND |=> reg_rdata == {4'h0, $past(active_profile_code)};
  endproperty
  a_ind_read: assert property (p_ind_read) else $error("indicator read wrong");
  property p_timing_b7;
    reg_rd && reg_addr == ADDR_FIRST_STIMULUS_SOURCE_TIMING |=> !reg_rdata[7];
  endproperty
  a_timing_b7: assert property (p_timing_b7) else $error("timing bit 7 set");
  property p_sleep_clear;
    sleep |=> active_profile_code == 4'h0;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("sleep kept profile");
  property p_load;
    profile_load && !sleep && profile_sel <= PROFILE_CUSTOM |=>
      active_profile_code == $past(profile_sel);
  endproperty
  a_load: assert property (p_load) else $error("profile not applied");
  property p_hold;
    (!profile_load || profile_sel > PROFILE_CUSTOM) && !sleep |=> $stable(active_profile_code);
  endproperty
  a_hold: assert property (p_hold) else $error("profile moved");
  property p_range;
    active_profile_code <= PROFILE_CUSTOM;
  endproperty
  a_range: assert property (p_range) else $error("unused profile code");
  property p_volt;
    first_response_type <= 4'h3 |-> resp_kind == CLASS_VOLTAGE;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage class wrong");
  property p_res;
    first_response_type inside {4'h4, 4'h7, 4'hD, 4'hE, 4'hF} |-> resp_kind == CLASS_RESISTOR;
  endproperty
  a_res: assert property (p_res) else $error("resistor class wrong");
  property p_div;
    first_response_type inside {4'h6, 4'h9, 4'hC} |-> resp_kind == CLASS_DIVIDER;
  endproperty
  a_div: assert property (p_div) else $error("divider class wrong");
endmodule : emu_profile_checker

bind emulation_profile_status_regs emu_profile_checker i_emu_profile_checker (.clk, .rstn,
  .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .profile_sel, .profile_load, .sleep,
  .active_profile_code, .resp_kind, .first_response_type);

// *** bench/emulation_profile_status_regs_tb.sv ***
// Self-checking bench for the emulation profile status registers.
`timescale 1ns/1ns
module emulation_profile_status_regs_tb;
  import emu_profile_pkg::*;
  localparam int MSC = 10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [3:0] profile_sel = 4'h0;
  logic profile_load = 1'b0;
  logic sleep = 1'b0;
  logic dp_above_th = 1'b0;
  logic dm_above_th = 1'b0;
  logic vbus_ready = 1'b0;
  logic vbus_present = 1'b0;
  logic dp_above_floor = 1'b0;
  logic [3:0] active_profile_code;
  logic resp_on;
  resp_class_t resp_kind;
  logic [3:0] first_response_type;
  logic [3:0] first_response_magnitude;
  logic stage_done;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  // Word 3 carries refused source, type and magnitude codes, so a load of it must change little.
  // Word 5 is a window comparator stimulus with a 1 ms delay.
  emulation_profile_status_regs #(.MS_CYC(MSC), .PROFILE_INIT({{5{16'h0026}}, 16'h0A24,
    16'h7B16, 16'h04F5, 16'h1124, 16'h4F31, 16'h0026})) i_emulation_profile_status_regs (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .profile_sel(profile_sel), .profile_load(profile_load),
    .sleep(sleep), .vbus_ready(vbus_ready), .vbus_present(vbus_present),
    .dp_above_th(dp_above_th), .dm_above_th(dm_above_th), .dp_above_floor(dp_above_floor),
    .active_profile_code(active_profile_code),
    .resp_on(resp_on), .resp_kind(resp_kind), .first_response_type(first_response_type),
    .first_response_magnitude(first_response_magnitude), .stage_done(stage_done));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #5 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #5 reg_rd = 1'b0;
    check("reg_rvalid", {7'h0, reg_rvalid}, 8'h01);
    check("reg_rdata", reg_rdata, exp);
  endtask : rd
  task load(input logic [3:0] s);
    @(posedge clk);
    #5 profile_sel = s;
    profile_load = 1'b1;
    @(posedge clk);
    #5 profile_load = 1'b0;
  endtask : load
  task t_reset;
    rd(8'h30, 8'h00);
    rd(8'h31, 8'h00);
    rd(8'h32, 8'h26);
    rd(8'h33, 8'h00);
    check("active_profile_code", {4'h0, active_profile_code}, 8'h00);
    check("first_response_type", {4'h0, first_response_type}, 8'h06);
    check("first_response_magnitude", {4'h0, first_response_magnitude}, 8'h02);
    check("resp_on", {7'h0, resp_on}, 8'h00);
  endtask : t_reset
  task t_load;
    load(4'h1);
    rd(8'h31, 8'h4F);
    load(4'h2);
    rd(8'h30, 8'h02);
    rd(8'h31, 8'h11);
    rd(8'h32, 8'h24);
    load(4'h3);
    rd(8'h31, 8'h01);
    rd(8'h32, 8'h24);
    load(4'hB);
    rd(8'h30, 8'h03);
    load(4'hA);
    rd(8'h30, 8'h0A);
    rd(8'h31, 8'h01);
  endtask : t_load
  task t_delay;
    int n;
    load(4'h2);
    repeat (3) @(posedge clk);
    #5 dp_above_th = 1'b1;
    n = 0;
    while (resp_on !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    check("delay", {7'h0, n >= 5 * MSC && n <= 5 * MSC + 6}, 8'h01);
    check("resp_kind", {6'h0, resp_kind}, {6'h0, CLASS_RESISTOR});
    check("first_response_magnitude", {4'h0, first_response_magnitude}, 8'h02);
    @(posedge clk);
    #5 dp_above_th = 1'b0;
    repeat (20) @(posedge clk);
    #1 check("stage_done", {7'h0, stage_done}, 8'h01);
  endtask : t_delay
  task t_hold;
    int n;
    load(4'h4);
    repeat (3) @(posedge clk);
    #5 dm_above_th = 1'b1;
    n = 0;
    while (resp_on !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    check("prompt", {7'h0, n <= 6}, 8'h01);
    check("resp_kind", {6'h0, resp_kind}, {6'h0, CLASS_DIVIDER});
    repeat (200) @(posedge clk);
    #5 dm_above_th = 1'b0;
    // The stimulus is gone early; the response must outlast it until the timer ends.
    repeat (700) @(posedge clk);
    #1 check("held", {7'h0, resp_on}, 8'h01);
    repeat (120) @(posedge clk);
    #1 check("removed", {7'h0, resp_on}, 8'h00);
  endtask : t_hold
  task t_sleep;
    @(posedge clk);
    #5 sleep = 1'b1;
    repeat (2) @(posedge clk);
    #5 sleep = 1'b0;
    rd(8'h30, 8'h00);
    rd(8'h31, 8'h00);
    rd(8'h32, 8'h16);
    load(4'h4);
    rd(8'h30, 8'h04);
    rd(8'h31, 8'h7B);
  endtask : t_sleep
  task wait_on(input int lim, output int n);
    n = 0;
    while (resp_on !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n = n + 1;
    end
  endtask : wait_on
  // Vbus stimuli end the stage while still present; the window needs the level between its two limits.
  task t_sources;
    int n;
    load(4'h0);
    repeat (3) @(posedge clk);
    #5 vbus_ready = 1'b1;
    wait_on(20, n);
    check("zero_delay", {7'h0, n <= 6}, 8'h01);
    repeat (2) @(posedge clk);
    #1 check("ready_done", {7'h0, stage_done}, 8'h01);
    load(4'h1);
    vbus_ready = 1'b0;
    repeat (3) @(posedge clk);
    #5 vbus_present = 1'b1;
    wait_on(20, n);
    check("present_on", {7'h0, n <= 6}, 8'h01);
    repeat (15) @(posedge clk);
    #1 check("present_done", {7'h0, stage_done && resp_on}, 8'h01);
    load(4'h5);
    vbus_present = 1'b0;
    dp_above_th = 1'b1;
    dp_above_floor = 1'b1;
    repeat (20) @(posedge clk);
    #1 check("window_above", {7'h0, resp_on}, 8'h00);
    #4 dp_above_th = 1'b0;
    wait_on(40, n);
    check("window_delay", {7'h0, n >= MSC && n <= MSC + 6}, 8'h01);
    @(posedge clk);
    #5 dp_above_floor = 1'b0;
  endtask : t_sources
  task conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (6) @(posedge clk);
    #5 rstn = 1'b1;
    t_reset();
    t_load();
    t_delay();
    t_hold();
    t_sleep();
    t_sources();
    conclude();
  end
endmodule : emulation_profile_status_regs_tb
